// ---- src/pevb_top.sv ----
// Value-sample event record builder: counter, record capture and word output
module pevb_top
  import pevb_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic [7:0]                     core_tag_field,
  input  wire logic                           prof_start,
  input  wire logic                           prof_start_ts_en,
  input  wire logic                           prof_stop,
  input  wire logic [63:0]                    perf_timestamp_counter,
  input  wire logic                           cnt_load,
  input  wire logic signed [PEVB_COUNT_W-1:0] cnt_load_value,
  input  wire logic                           vs_exec,
  input  wire logic [63:0]                    vs_insn_address,
  input  wire logic [31:0]                    vs_immediate,
  input  wire logic [31:0]                    vs_operand_a,
  input  wire logic [63:0]                    vs_operand_b,
  input  wire logic                           legacy_mode,
  input  wire logic                           ring_ready,
  output logic [PEVB_WORD_W-1:0]              ring_wdata,
  output logic                                ring_wvalid,
  output logic                                ring_wlast,
  output logic [1:0]                          ring_widx,
  output logic                                record_dropped,
  output logic signed [PEVB_COUNT_W-1:0]      sample_count
);
  import pevb_pkg::*;

  // ==========================================================================
  // Internal signals
  pevb_rec_if rec_if ();

  logic      active_reg;
  logic      ts_en_reg;
  logic      underflow;
  logic      slot_free;
  logic      accept;
  logic      rec_valid_reg;
  pevb_rec_s rec_reg;
  pevb_rec_s rec_next;
  logic      dropped_reg;

  // ==========================================================================
  // Profiling session state
  // The timestamp choice is frozen at start so that a session never mixes
  // stamped and unstamped records.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_reg <= 1'b0;
    end else if (prof_start) begin
      active_reg <= 1'b1;
    end else if (prof_stop) begin
      active_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ts_en_reg <= 1'b0;
    end else if (prof_start) begin
      ts_en_reg <= prof_start_ts_en;
    end
  end

  // ==========================================================================
  // Value-sample counter
  pevb_counter u_counter (
    .clk        (clk),
    .resetn     (resetn),
    .load       (cnt_load),
    .load_value (cnt_load_value),
    .dec        (vs_exec && active_reg),
    .underflow  (underflow),
    .count_reg  (sample_count)
  );

  // ==========================================================================
  // Record assembly
  always_comb begin
    rec_next           = PEVB_REC_ZERO;
    rec_next.type_code = PEVB_TYPE_VALUE_SAMPLE;
    rec_next.core_tag  = core_tag_field;
    rec_next.flags     = vs_immediate[15:0];
    rec_next.data_a    = vs_operand_a;
    rec_next.insn_addr = vs_insn_address;
    if (legacy_mode) begin
      rec_next.data_b = {32'h0000_0000, vs_operand_b[31:0]};
    end else begin
      rec_next.data_b = vs_operand_b;
    end
    rec_next.timestamp = ts_en_reg ? perf_timestamp_counter : 64'h0;
  end

  // One record slot only: a second underflow while the slot is still busy
  // is dropped and flagged, never merged or delayed.
  assign slot_free = !rec_valid_reg || rec_if.ready;
  assign accept    = underflow && slot_free;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rec_valid_reg <= 1'b0;
    end else if (accept) begin
      rec_valid_reg <= 1'b1;
    end else if (rec_if.ready) begin
      rec_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rec_reg <= PEVB_REC_ZERO;
    end else if (accept) begin
      rec_reg <= rec_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dropped_reg <= 1'b0;
    end else begin
      dropped_reg <= underflow && !slot_free;
    end
  end

  assign rec_if.rec   = rec_reg;
  assign rec_if.valid = rec_valid_reg;
  assign record_dropped = dropped_reg;

  // ==========================================================================
  // Word output
  pevb_packer u_packer (
    .clk             (clk),
    .resetn          (resetn),
    .rec_in          (rec_if.snk),
    .ring_ready      (ring_ready),
    .ring_wdata_reg  (ring_wdata),
    .ring_wvalid_reg (ring_wvalid),
    .ring_wlast_reg  (ring_wlast),
    .ring_widx_reg   (ring_widx)
  );

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  type_nonzero_a : assert property (
    ring_wvalid && ring_widx == PEVB_WORD_FIRST |-> ring_wdata[7:0] != PEVB_TYPE_INVALID)
    else $error("record type byte is zero");

  type_value_a : assert property (
    ring_wvalid && ring_widx == PEVB_WORD_FIRST
      |-> ring_wdata[7:0] == PEVB_TYPE_VALUE_SAMPLE)
    else $error("value sample record has wrong type");

  core_tag_a : assert property (
    accept |=> rec_reg.core_tag == $past(core_tag_field))
    else $error("core tag not copied");

  flags_low_a : assert property (
    accept |=> rec_reg.flags == $past(vs_immediate[15:0]))
    else $error("flags differ from immediate");

  operand_a_a : assert property (
    accept |=> rec_reg.data_a == $past(vs_operand_a))
    else $error("data word a wrong");

  legacy_zext_a : assert property (
    accept && legacy_mode |=> rec_reg.data_b[63:32] == 32'h0000_0000)
    else $error("legacy operand not zero extended");

  insn_addr_a : assert property (
    accept |=> rec_reg.insn_addr == $past(vs_insn_address))
    else $error("instruction address wrong");

  ts_zero_a : assert property (
    accept && !ts_en_reg |=> rec_reg.timestamp == 64'h0)
    else $error("timestamp not zero when disabled");

  count_dec_a : assert property (
    vs_exec && active_reg && !cnt_load |=> sample_count == $past(sample_count) - 1)
    else $error("counter did not step by one");

  // Only an idle packer has a fixed latency; a stalled ring may hold a record indefinitely
  fire_record_a : assert property (
    accept && !rec_valid_reg && rec_if.ready
      |=> rec_valid_reg ##1 ring_wvalid && ring_widx == PEVB_WORD_FIRST)
    else $error("underflow produced no record");

  word_order_a : assert property (
    ring_wvalid && ring_ready && !ring_wlast |=> ring_widx == $past(ring_widx) + 2'h1)
    else $error("words out of order");

  last_word_a : assert property (
    ring_wvalid && ring_wlast |-> ring_widx == PEVB_WORD_LAST)
    else $error("last flag on wrong word");

  record_sent_c : cover property (
    ring_wvalid && ring_ready && ring_wlast);
  record_drop_c : cover property (record_dropped);
  ring_stall_c  : cover property (ring_wvalid && !ring_ready [*3]);
  stamped_rec_c : cover property (accept && ts_en_reg);

endmodule // pevb_top

// ---- src/pevb_pkg.sv ----
// Constants, record layout and packing function for the profiling event record builder
//
// What this block does
// - Byte 0 holds an 8-bit type code from 1 to 255, never 0.
// - Byte 1 holds the core tag taken from the profiling configuration.
// - Generic layout: flags bytes 3-2, data 7-4, address/data 23-16.
// - Bytes 15-8 hold the effective address, before any code segment base.
// - Bytes 31-24 hold the timestamp when enabled at start, else zero.
// - Type codes: 0 invalid, 1 value sample, 2 to 6 others, 255 programmed.
// - Each value-sample instruction during a profiling session decrements the value-sample counter by one.
// - When that counter goes negative a type 1 record is stored; the code drops and flags it instead while the one record slot is busy.
// - Value-sample flags carry the low 16 bits of the immediate operand.
// - Value-sample bytes 7-4 carry the register-or-memory operand.
// - Value-sample bytes 23-16 carry the register operand, zero-extended in legacy mode.
// - Value-sample address field holds the address of that instruction.
// - Reserved and undefined fields are written as zero.
// - Every record is 32 bytes; field offsets count from record start.
package pevb_pkg;

  // ==========================================================================
  // Record type codes
  localparam logic [7:0] PEVB_TYPE_INVALID      = 8'h00;
  localparam logic [7:0] PEVB_TYPE_VALUE_SAMPLE = 8'h01;
  localparam logic [7:0] PEVB_TYPE_INSN_RETIRED = 8'h02;
  localparam logic [7:0] PEVB_TYPE_BR_RETIRED   = 8'h03;
  localparam logic [7:0] PEVB_TYPE_DC_MISS      = 8'h04;
  localparam logic [7:0] PEVB_TYPE_CORE_CLK     = 8'h05;
  localparam logic [7:0] PEVB_TYPE_REF_CLK      = 8'h06;
  localparam logic [7:0] PEVB_TYPE_PROGRAMMED   = 8'hff;

  // ==========================================================================
  // Record geometry
  localparam int         PEVB_RECORD_BYTES = 32;
  localparam int         PEVB_WORD_BYTES   = 8;
  localparam int         PEVB_WORD_W       = 64;
  localparam logic [1:0] PEVB_WORD_FIRST   = 2'h0;
  localparam logic [1:0] PEVB_WORD_LAST    = 2'h3;
  localparam int         PEVB_COUNT_W      = 32;
  localparam logic [PEVB_COUNT_W-1:0] PEVB_COUNT_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    PEVB_W_HEAD = 2'b00,
    PEVB_W_ADDR = 2'b01,
    PEVB_W_DATA = 2'b10,
    PEVB_W_TIME = 2'b11
  } pevb_word_e;

  typedef struct packed {
    logic [7:0]  type_code;
    logic [7:0]  core_tag;
    logic [15:0] flags;
    logic [31:0] data_a;
    logic [63:0] insn_addr;
    logic [63:0] data_b;
    logic [63:0] timestamp;
  } pevb_rec_s;

  localparam pevb_rec_s PEVB_REC_ZERO = '0;

  // Little-endian word of a record: type in byte 0 up to data_a in bytes 7-4
  function automatic logic [PEVB_WORD_W-1:0] pevb_record_word(input pevb_rec_s rec,
                                                               input logic [1:0] idx);
    logic [PEVB_WORD_W-1:0] w;
    w = '0;
    case (pevb_word_e'(idx))
      PEVB_W_HEAD: w = {rec.data_a, rec.flags, rec.core_tag, rec.type_code};
      PEVB_W_ADDR: w = rec.insn_addr;
      PEVB_W_DATA: w = rec.data_b;
      PEVB_W_TIME: w = rec.timestamp;
      default:     w = '0;
    endcase
    return w;
  endfunction

endpackage

// ---- src/pevb_rec_if.sv ----
// Record hand-off between the record builder and the word packer
interface pevb_rec_if;
  import pevb_pkg::*;
  pevb_rec_s rec;
  logic      valid;
  logic      ready;
  modport src (output rec, output valid, input ready);
  modport snk (input rec, input valid, output ready);
endinterface // pevb_rec_if

// ---- src/pevb_counter.sv ----
// Value-sample down-counter with underflow detection
module pevb_counter
  import pevb_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic                           load,
  input  wire logic signed [PEVB_COUNT_W-1:0] load_value,
  input  wire logic                           dec,
  output logic                                underflow,
  output logic signed [PEVB_COUNT_W-1:0]      count_reg
);
  // Underflow is the step from zero to minus one; a counter already below
  // zero keeps counting without firing until software reloads it.
  assign underflow = dec && !load && (count_reg == PEVB_COUNT_RESET);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= PEVB_COUNT_RESET;
    end else if (load) begin
      count_reg <= load_value;
    end else if (dec) begin
      count_reg <= count_reg - 32'sh0000_0001;
    end
  end
endmodule // pevb_counter

// ---- src/pevb_packer.sv ----
// Serialises one captured record into four 64-bit ring words
module pevb_packer
  import pevb_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          resetn,
  pevb_rec_if.snk            rec_in,
  input  wire logic          ring_ready,
  output logic [PEVB_WORD_W-1:0] ring_wdata_reg,
  output logic               ring_wvalid_reg,
  output logic               ring_wlast_reg,
  output logic [1:0]         ring_widx_reg
);
  typedef enum logic {
    PEVB_PK_IDLE = 1'b0,
    PEVB_PK_SEND = 1'b1
  } pevb_pk_e;

  pevb_pk_e  state_reg;
  pevb_rec_s rec_reg;

  assign rec_in.ready = (state_reg == PEVB_PK_IDLE);

  // ==========================================================================
  // Word sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg       <= PEVB_PK_IDLE;
      rec_reg         <= PEVB_REC_ZERO;
      ring_wdata_reg  <= '0;
      ring_wvalid_reg <= 1'b0;
      ring_wlast_reg  <= 1'b0;
      ring_widx_reg   <= PEVB_WORD_FIRST;
    end else begin
      case (state_reg)
        PEVB_PK_IDLE: begin
          if (rec_in.valid) begin
            state_reg       <= PEVB_PK_SEND;
            rec_reg         <= rec_in.rec;
            ring_wdata_reg  <= pevb_record_word(rec_in.rec, PEVB_WORD_FIRST);
            ring_wvalid_reg <= 1'b1;
            ring_wlast_reg  <= 1'b0;
            ring_widx_reg   <= PEVB_WORD_FIRST;
          end
        end
        PEVB_PK_SEND: begin
          if (ring_ready) begin
            if (ring_widx_reg == PEVB_WORD_LAST) begin
              state_reg       <= PEVB_PK_IDLE;
              ring_wvalid_reg <= 1'b0;
              ring_wlast_reg  <= 1'b0;
            end else begin
              ring_widx_reg  <= ring_widx_reg + 2'h1;
              ring_wdata_reg <= pevb_record_word(rec_reg, ring_widx_reg + 2'h1);
              ring_wlast_reg <= (ring_widx_reg + 2'h1) == PEVB_WORD_LAST;
            end
          end
        end
        default: begin
          state_reg       <= PEVB_PK_IDLE;
          ring_wvalid_reg <= 1'b0;
        end
      endcase
    end
  end
endmodule // pevb_packer

// ---- test/pevb_ring_model.sv ----
// Ring buffer model that takes record words into consecutive locations
module pevb_ring_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        stall,
  input  wire logic [63:0] ring_wdata,
  input  wire logic        ring_wvalid,
  input  wire logic        ring_wlast,
  input  wire logic [1:0]  ring_widx,
  output logic             ring_ready
);
  logic [63:0] mem [0:63];
  logic [2:0]  tag_mem [0:63];
  int          head;

  // ==========================================================================
  // Acceptance
  // Ready follows the stall request one edge late, as a slow memory port would
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) ring_ready <= 1'b0;
    else ring_ready <= !stall;
  end

  // Each accepted word lands in the next 8-byte slot; only 64 words are kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      head <= 0;
    end else if (ring_wvalid && ring_ready) begin
      mem[head % 64]     <= ring_wdata;
      tag_mem[head % 64] <= {ring_wlast, ring_widx};
      head               <= head + 1;
    end
  end
endmodule // pevb_ring_model

// ---- test/tb_top.sv ----
// Self-checking bench for the value-sample record builder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pevb_pkg::*;

  logic        clk = 0, resetn = 0, stall = 0;
  logic [7:0]  core_tag_field = 8'h5a;
  logic        prof_start = 0, prof_start_ts_en = 0, prof_stop = 0;
  logic [63:0] perf_timestamp_counter = 64'h0000_00ab_cdef_0123;
  logic        cnt_load = 0, vs_exec = 0, legacy_mode = 0;
  logic signed [PEVB_COUNT_W-1:0] cnt_load_value = '0;
  logic [63:0] vs_insn_address = '0, vs_operand_b = '0;
  logic [31:0] vs_immediate = '0, vs_operand_a = '0;
  logic        ring_ready, ring_wvalid, ring_wlast, record_dropped;
  logic [63:0] ring_wdata;
  logic [1:0]  ring_widx;
  logic signed [PEVB_COUNT_W-1:0] sample_count;
  int          failures = 0, checked = 0, drops = 0;

  pevb_top dut (.clk(clk), .resetn(resetn), .core_tag_field(core_tag_field),
    .prof_start(prof_start), .prof_start_ts_en(prof_start_ts_en), .prof_stop(prof_stop),
    .perf_timestamp_counter(perf_timestamp_counter), .cnt_load(cnt_load),
    .cnt_load_value(cnt_load_value), .vs_exec(vs_exec), .vs_insn_address(vs_insn_address),
    .vs_immediate(vs_immediate), .vs_operand_a(vs_operand_a), .vs_operand_b(vs_operand_b),
    .legacy_mode(legacy_mode), .ring_ready(ring_ready), .ring_wdata(ring_wdata),
    .ring_wvalid(ring_wvalid), .ring_wlast(ring_wlast), .ring_widx(ring_widx),
    .record_dropped(record_dropped), .sample_count(sample_count));

  pevb_ring_model ring (.clk(clk), .resetn(resetn), .stall(stall), .ring_wdata(ring_wdata),
    .ring_wvalid(ring_wvalid), .ring_wlast(ring_wlast), .ring_widx(ring_widx),
    .ring_ready(ring_ready));

  initial begin
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (record_dropped === 1'b1) drops++;
  end

  // ==========================================================================
  // Helpers
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic start_session(input logic ts);
    @(posedge clk) begin prof_start <= 1'b1; prof_start_ts_en <= ts; end
    @(posedge clk) prof_start <= 1'b0;
  endtask

  task automatic load(input logic [31:0] v);
    @(posedge clk) begin cnt_load <= 1'b1; cnt_load_value <= v; end
    @(posedge clk) cnt_load <= 1'b0;
  endtask

  // Operands are scrambled after the exec edge so a late capture shows up
  task automatic exec(input logic [63:0] addr, input logic [31:0] imm, input logic [31:0] a,
                      input logic [63:0] b, input logic leg);
    @(posedge clk) begin
      vs_exec <= 1'b1; vs_insn_address <= addr; vs_immediate <= imm;
      vs_operand_a <= a; vs_operand_b <= b; legacy_mode <= leg;
    end
    @(posedge clk) begin
      vs_exec <= 1'b0; vs_insn_address <= ~addr; vs_immediate <= ~imm;
      vs_operand_a <= ~a; vs_operand_b <= ~b; legacy_mode <= ~leg;
    end
    // Counter and slot settle in the update region of that edge, so look half a cycle later
    @(negedge clk);
  endtask

  task automatic wait_words(input int n);
    int i;
    for (i = 0; i < 300 && ring.head < n; i++) @(posedge clk);
    if (ring.head < n) begin
      failures++;
      $display("Error ring words expected %0d seen %0d", n, ring.head);
      complete_run();
    end
  endtask

  task automatic check_rec(input int base, input logic [63:0] addr, input logic [31:0] imm,
                           input logic [31:0] a, input logic [63:0] b, input logic [63:0] ts);
    int i;
    check("word0", ring.mem[base], {a, imm[15:0], core_tag_field, 8'h01});
    check("word1", ring.mem[base+1], addr);
    check("word2", ring.mem[base+2], b);
    check("word3", ring.mem[base+3], ts);
    for (i = 0; i < 4; i++) begin
      check("index", {61'h0, ring.tag_mem[base+i]}, {61'h0, i == 3, i[1:0]});
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic sc_single();
    start_session(1'b1);
    load(32'h0000_0000);
    exec(64'hffff_8000_1234_5678, 32'hdead_beef, 32'h8765_4321, 64'hfedc_ba98_7654_3210, 1'b0);
    check("count", {32'h0, sample_count}, 64'h0000_0000_ffff_ffff);
    wait_words(4);
    check_rec(0, 64'hffff_8000_1234_5678, 32'hdead_beef, 32'h8765_4321,
              64'hfedc_ba98_7654_3210, perf_timestamp_counter);
  endtask

  // Three executions from 2 give one record only; ring stalls on the way
  task automatic sc_countdown_legacy();
    prof_stop <= 1'b1;
    @(posedge clk) prof_stop <= 1'b0;
    start_session(1'b0);
    load(32'h0000_0002);
    stall <= 1'b1;
    exec(64'h10, 32'h1, 32'h1, 64'h1, 1'b1);
    exec(64'h20, 32'h2, 32'h2, 64'h2, 1'b1);
    check("count", {32'h0, sample_count}, 64'h0);
    check("head", ring.head, 4);
    exec(64'h0000_0000_0040_0100, 32'h0001_a55a, 32'hcafe_f00d, 64'h1234_5678_9abc_def0, 1'b1);
    repeat (10) @(posedge clk);
    check("stalled", ring.head, 4);
    check("held idx", {62'h0, ring_widx}, 64'h0);
    stall <= 1'b0;
    wait_words(8);
    check_rec(4, 64'h0000_0000_0040_0100, 32'h0001_a55a, 32'hcafe_f00d,
              64'h0000_0000_9abc_def0, 64'h0);
  endtask

  task automatic sc_inactive();
    prof_stop <= 1'b1;
    @(posedge clk) prof_stop <= 1'b0;
    load(32'h0000_0000);
    exec(64'h30, 32'h3, 32'h3, 64'h3, 1'b0);
    repeat (8) @(posedge clk);
    check("count idle", {32'h0, sample_count}, 64'h0);
    check("head idle", ring.head, 8);
  endtask

  // Three underflows against a stalled ring: one in the packer, one in the slot, one lost
  task automatic sc_overrun();
    int k;
    start_session(1'b1);
    stall <= 1'b1;
    for (k = 0; k < 3; k++) begin
      load(32'h0000_0000);
      exec(64'h100 + k, 32'h4 + k, 32'h40 + k, 64'h400 + k, 1'b0);
    end
    repeat (3) @(posedge clk);
    check("drops", drops, 1);
    stall <= 1'b0;
    wait_words(16);
    repeat (20) @(posedge clk);
    check("head end", ring.head, 16);
    check_rec(8, 64'h100, 32'h4, 32'h40, 64'h400, perf_timestamp_counter);
    check_rec(12, 64'h101, 32'h5, 32'h41, 64'h401, perf_timestamp_counter);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    check("wvalid rst", {63'h0, ring_wvalid}, 64'h0);
    check("count rst", {32'h0, sample_count}, 64'h0);
    sc_single();
    sc_countdown_legacy();
    sc_inactive();
    sc_overrun();
    complete_run();
  end
endmodule // tb_top
